// >>> rtl/sar_seq_pkg.sv
package sar_seq_pkg;

  // Clock and resolution
  localparam int CLK_PERIOD_NS = 50;
  localparam int RES_BITS = 18;

  // Throughput limits per mode, in kSPS
  localparam int FAST_RATE_KSPS = 800;
  localparam int NORMAL_RATE_KSPS = 666;
  localparam int LOW_POWER_RATE_KSPS = 570;

  // Least start-to-start period per mode, rounded up
  localparam int FAST_PERIOD_NS =
    (1000000 + FAST_RATE_KSPS - 1) / FAST_RATE_KSPS;
  localparam int NORMAL_PERIOD_NS =
    (1000000 + NORMAL_RATE_KSPS - 1) / NORMAL_RATE_KSPS;
  localparam int LOW_POWER_PERIOD_NS =
    (1000000 + LOW_POWER_RATE_KSPS - 1) / LOW_POWER_RATE_KSPS;
  localparam int FAST_PERIOD_CYC =
    (FAST_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NORMAL_PERIOD_CYC =
    (NORMAL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_POWER_PERIOD_CYC =
    (LOW_POWER_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Longest idle gap in fast mode before a result goes stale
  localparam int STALE_GAP_MS = 1;
  localparam int STALE_GAP_CYC = STALE_GAP_MS * 1000000 / CLK_PERIOD_NS;

  // Settling cycles per bit trial
  localparam int STEP_CYCLES = 1;

  // Register map, byte addresses
  localparam int ADDR_WIDTH = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] RESULT_OFFSET = 12'h008;

  // Control fields and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DROP_STALE_BIT = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic CTRL_DROP_STALE_RESET = 1'b0;

  // Status fields
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_EMPTY_BIT = 1;
  localparam int STATUS_FULL_BIT = 2;
  localparam int STATUS_MODE_LSB = 3;
  localparam int STATUS_PD_BIT = 5;
  localparam int STATUS_OVERFLOW_BIT = 6;
  localparam int STATUS_STALE_BIT = 7;
  localparam int STATUS_COUNT_LSB = 8;

  // Result fields
  localparam int RESULT_STALE_BIT = 18;
  localparam int RESULT_VALID_BIT = 31;

  // Extreme codes per coding
  localparam logic [17:0] OB_MAX_CODE = 18'h3FFFF;
  localparam logic [17:0] OB_MIN_CODE = 18'h00000;
  localparam logic [17:0] TC_MAX_CODE = 18'h1FFFF;
  localparam logic [17:0] TC_MIN_CODE = 18'h20000;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_FAST = 2'b01,
    MODE_LOW_POWER = 2'b10
  } mode_t;

  typedef enum logic [2:0] {
    ST_ACQUIRE = 3'b000,
    ST_OPEN_SWITCHES = 3'b001,
    ST_TO_REF_GROUND = 3'b010,
    ST_BIT_TRIAL = 3'b011,
    ST_FORM_CODE = 3'b100
  } conv_state_t;

endpackage : sar_seq_pkg

// >>> rtl/result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t state;
  fifo_state_t next_state;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("result_fifo: DEPTH must be a power of two >= 2");
    end
  end

  // Honest flags from the occupancy count
  assign in_ready = (state.count != DEPTH[AW:0]);
  assign out_valid = (state.count != '0);
  assign out_data = mem[state.rd_ptr];
  assign count = state.count;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.wr_ptr = state.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_state.rd_ptr = state.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[state.wr_ptr] <= in_data;
    end
  end

endmodule : result_fifo

// >>> rtl/sar_conversion_sequencer.sv
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Falling start edge begins a conversion
// - Open ground switches, then tie arrays
// - Eighteen bit trials, most significant first
// - Form code, then drop busy
// - Each result from its own sample
// - Three modes: fast, normal, low power
// - Fast mode up to 800 kSPS
// - Normal mode up to 666 kSPS
// - Low power saves between conversions, 570 kSPS
// - Coding select unless full-width mode
// - Offset binary or twos complement codes
// - Out-of-range inputs saturate to extremes
// - Reset aborts conversion, returns to idle
// - Power-down finishes current, refuses new
// - Low power: start held low starts
module sar_conversion_sequencer #(
  parameter int GAP_CYCLES = sar_seq_pkg::STALE_GAP_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic conversion_start_n,
  input wire logic fast_mode_in,
  input wire logic low_power_mode_in,
  input wire logic coding_select,
  input wire logic full_width_mode_in,
  input wire logic power_down_in,
  input wire logic comparator_in,
  input wire logic over_range_in,
  input wire logic under_range_in,
  output logic busy,
  output logic pos_array_ground_switch,
  output logic neg_array_ground_switch,
  output logic array_to_reference_ground,
  output logic [17:0] array_switch,
  output logic power_save,
  output logic [17:0] result_code,
  output logic result_stale,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int FW = sar_seq_pkg::RES_BITS + 1;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    sar_seq_pkg::conv_state_t st;
    sar_seq_pkg::mode_t conv_mode;
    logic prev_start_n;
    logic [4:0] bit_idx;
    logic [3:0] step_cnt;
    logic [7:0] period_cnt;
    logic [15:0] gap_cnt;
    logic stale_pending;
    logic conv_stale;
    logic busy;
    logic ground_sw;
    logic ref_ground;
    logic [17:0] sar;
    logic [17:0] result;
    logic result_stale;
    logic power_save;
    logic ctrl_enable;
    logic ctrl_drop_stale;
    logic overflow;
    logic [31:0] prdata;
  } seq_state_t;

  seq_state_t state;
  seq_state_t next_state;
  sar_seq_pkg::mode_t mode_now;
  logic [7:0] period_need;
  logic acq_done;
  logic acq_done_now;
  logic start_edge;
  logic start_req;
  logic start_ok;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FW-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic [CW-1:0] fifo_count;
  logic [17:0] final_code;
  logic twos;
  logic apb_setup;
  logic apb_access;
  logic mapped;

  initial begin
    if (GAP_CYCLES < 1 || GAP_CYCLES > 65535) begin
      $error("GAP_CYCLES must be between 1 and 65535");
    end
    if (FIFO_DEPTH != 16 && FIFO_DEPTH != 8 && FIFO_DEPTH != 32) begin
      $error("FIFO_DEPTH must be 8, 16 or 32");
    end
  end

  // Mode decode; both inputs high falls back to normal
  always_comb begin
    if (fast_mode_in && !low_power_mode_in) begin
      mode_now = sar_seq_pkg::MODE_FAST;
    end else if (low_power_mode_in && !fast_mode_in) begin
      mode_now = sar_seq_pkg::MODE_LOW_POWER;
    end else begin
      mode_now = sar_seq_pkg::MODE_NORMAL;
    end
  end

  // Least start-to-start spacing of the running mode
  always_comb begin
    case (state.conv_mode)
      sar_seq_pkg::MODE_FAST:
        period_need = 8'(sar_seq_pkg::FAST_PERIOD_CYC);
      sar_seq_pkg::MODE_LOW_POWER:
        period_need = 8'(sar_seq_pkg::LOW_POWER_PERIOD_CYC);
      default:
        period_need = 8'(sar_seq_pkg::NORMAL_PERIOD_CYC);
    endcase
  end

  // Start qualification
  assign acq_done = (state.period_cnt >= period_need);
  assign acq_done_now = (state.period_cnt == period_need);
  assign start_edge = state.prev_start_n & ~conversion_start_n;
  assign start_req = start_edge |
    ((mode_now == sar_seq_pkg::MODE_LOW_POWER) & ~conversion_start_n &
     acq_done_now);
  assign start_ok = (state.st == sar_seq_pkg::ST_ACQUIRE) & acq_done &
    ~power_down_in & state.ctrl_enable & fifo_in_ready;

  // Output coding with saturation
  assign twos = coding_select & ~full_width_mode_in;
  always_comb begin
    if (over_range_in) begin
      final_code = twos ? sar_seq_pkg::TC_MAX_CODE
                        : sar_seq_pkg::OB_MAX_CODE;
    end else if (under_range_in) begin
      final_code = twos ? sar_seq_pkg::TC_MIN_CODE
                        : sar_seq_pkg::OB_MIN_CODE;
    end else if (twos) begin
      final_code = {~state.sar[17], state.sar[16:0]};
    end else begin
      final_code = state.sar;
    end
  end

  // Result push, optionally dropping stale fast-mode results
  assign fifo_in_valid = (state.st == sar_seq_pkg::ST_FORM_CODE) &
    ~(state.ctrl_drop_stale & state.conv_stale);
  assign fifo_in_data = {state.conv_stale, final_code};

  // Bus decode
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign mapped = (paddr == sar_seq_pkg::CTRL_OFFSET) |
    (paddr == sar_seq_pkg::STATUS_OFFSET) |
    (paddr == sar_seq_pkg::RESULT_OFFSET);
  assign pready = 1'b1;
  assign pslverr = apb_access & ~mapped;
  assign fifo_out_ready = apb_access & ~pwrite &
    (paddr == sar_seq_pkg::RESULT_OFFSET);

  // Sequencer, gap tracking and register file
  always_comb begin
    next_state = state;
    next_state.prev_start_n = conversion_start_n;
    if (state.period_cnt != 8'hFF) begin
      next_state.period_cnt = state.period_cnt + 8'h01;
    end
    // Idle time since the last conversion ended
    if (state.busy) begin
      next_state.gap_cnt = '0;
    end else if (state.gap_cnt >= 16'(GAP_CYCLES)) begin
      next_state.stale_pending = 1'b1;
    end else begin
      next_state.gap_cnt = state.gap_cnt + 16'h0001;
    end
    case (state.st)
      sar_seq_pkg::ST_ACQUIRE: begin
        next_state.power_save =
          (mode_now == sar_seq_pkg::MODE_LOW_POWER) | power_down_in;
        if (start_req && start_ok) begin
          next_state.st = sar_seq_pkg::ST_OPEN_SWITCHES;
          next_state.busy = 1'b1;
          next_state.power_save = 1'b0;
          next_state.conv_mode = mode_now;
          next_state.period_cnt = 8'h01;
          next_state.conv_stale = next_state.stale_pending &
            (mode_now == sar_seq_pkg::MODE_FAST);
          next_state.stale_pending = 1'b0;
          next_state.ground_sw = 1'b0;
        end else if (start_req && !fifo_in_ready) begin
          next_state.overflow = 1'b1;
        end
      end
      sar_seq_pkg::ST_OPEN_SWITCHES: begin
        next_state.ref_ground = 1'b1;
        next_state.sar = 18'h20000;
        next_state.bit_idx = 5'd17;
        next_state.step_cnt = '0;
        next_state.st = sar_seq_pkg::ST_TO_REF_GROUND;
      end
      sar_seq_pkg::ST_TO_REF_GROUND: begin
        next_state.st = sar_seq_pkg::ST_BIT_TRIAL;
      end
      sar_seq_pkg::ST_BIT_TRIAL: begin
        if (state.step_cnt != 4'(sar_seq_pkg::STEP_CYCLES - 1)) begin
          next_state.step_cnt = state.step_cnt + 4'h1;
        end else begin
          // Keep or drop trial bit, then try next weight
          next_state.step_cnt = '0;
          next_state.sar[state.bit_idx] = comparator_in;
          if (state.bit_idx == 5'd0) begin
            next_state.st = sar_seq_pkg::ST_FORM_CODE;
          end else begin
            next_state.sar[state.bit_idx - 5'd1] = 1'b1;
            next_state.bit_idx = state.bit_idx - 5'd1;
          end
        end
      end
      sar_seq_pkg::ST_FORM_CODE: begin
        next_state.result = final_code;
        next_state.result_stale = state.conv_stale;
        next_state.busy = 1'b0;
        next_state.ground_sw = 1'b1;
        next_state.ref_ground = 1'b0;
        next_state.st = sar_seq_pkg::ST_ACQUIRE;
      end
      default: begin
        next_state.st = sar_seq_pkg::ST_ACQUIRE;
        next_state.busy = 1'b0;
        next_state.ground_sw = 1'b1;
        next_state.ref_ground = 1'b0;
      end
    endcase
    // Register writes in the access phase
    if (apb_access && pwrite) begin
      if (paddr == sar_seq_pkg::CTRL_OFFSET) begin
        next_state.ctrl_enable = pwdata[sar_seq_pkg::CTRL_ENABLE_BIT];
        next_state.ctrl_drop_stale =
          pwdata[sar_seq_pkg::CTRL_DROP_STALE_BIT];
      end else if (paddr == sar_seq_pkg::STATUS_OFFSET &&
                   pwdata[sar_seq_pkg::STATUS_OVERFLOW_BIT] &&
                   !(state.st == sar_seq_pkg::ST_ACQUIRE && start_req &&
                     !fifo_in_ready)) begin
        next_state.overflow = 1'b0;
      end
    end
    // Read data captured in the setup phase
    if (apb_setup) begin
      next_state.prdata = 32'h00000000;
      case (paddr)
        sar_seq_pkg::CTRL_OFFSET: begin
          next_state.prdata[sar_seq_pkg::CTRL_ENABLE_BIT] = state.ctrl_enable;
          next_state.prdata[sar_seq_pkg::CTRL_DROP_STALE_BIT] =
            state.ctrl_drop_stale;
        end
        sar_seq_pkg::STATUS_OFFSET: begin
          next_state.prdata[sar_seq_pkg::STATUS_BUSY_BIT] = state.busy;
          next_state.prdata[sar_seq_pkg::STATUS_EMPTY_BIT] = ~fifo_out_valid;
          next_state.prdata[sar_seq_pkg::STATUS_FULL_BIT] = ~fifo_in_ready;
          next_state.prdata[sar_seq_pkg::STATUS_MODE_LSB +: 2] = mode_now;
          next_state.prdata[sar_seq_pkg::STATUS_PD_BIT] = power_down_in;
          next_state.prdata[sar_seq_pkg::STATUS_OVERFLOW_BIT] = state.overflow;
          next_state.prdata[sar_seq_pkg::STATUS_STALE_BIT] =
            state.stale_pending;
          next_state.prdata[sar_seq_pkg::STATUS_COUNT_LSB +: CW] = fifo_count;
        end
        sar_seq_pkg::RESULT_OFFSET: begin
          next_state.prdata[FW-1:0] = fifo_out_data;
          next_state.prdata[sar_seq_pkg::RESULT_VALID_BIT] = fifo_out_valid;
        end
        default: begin
          next_state.prdata = 32'h00000000;
        end
      endcase
    end
  end

  // State register; reset aborts any conversion
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
      state.st <= sar_seq_pkg::ST_ACQUIRE;
      state.conv_mode <= sar_seq_pkg::MODE_NORMAL;
      state.prev_start_n <= 1'b1;
      state.period_cnt <= 8'hFF;
      state.stale_pending <= 1'b1;
      state.ground_sw <= 1'b1;
      state.ctrl_enable <= sar_seq_pkg::CTRL_ENABLE_RESET;
      state.ctrl_drop_stale <= sar_seq_pkg::CTRL_DROP_STALE_RESET;
    end else begin
      state <= next_state;
    end
  end

  result_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  // Outputs straight from the state register
  assign busy = state.busy;
  assign pos_array_ground_switch = state.ground_sw;
  assign neg_array_ground_switch = state.ground_sw;
  assign array_to_reference_ground = state.ref_ground;
  assign array_switch = state.sar;
  assign power_save = state.power_save;
  assign result_code = state.result;
  assign result_stale = state.result_stale;
  assign prdata = state.prdata;

endmodule : sar_conversion_sequencer

// >>> bench/sar_seq_asserts.sv
`timescale 1ns/1ps
module sar_seq_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic conversion_start_n,
  input wire logic power_down_in,
  input wire logic busy,
  input wire logic pos_array_ground_switch,
  input wire logic neg_array_ground_switch,
  input wire logic array_to_reference_ground,
  input wire logic [17:0] array_switch,
  input wire logic [17:0] result_code,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Conversion sequence
  a_start_cause: assert property (
    $rose(busy) |-> !$past(conversion_start_n))
    else $error("busy rose without a low start");
  a_switch_order: assert property (
    $rose(busy) |-> !pos_array_ground_switch && !neg_array_ground_switch
    && !array_to_reference_ground ##1 array_to_reference_ground)
    else $error("switches not opened before reference ground");
  a_msb_first: assert property (
    $rose(array_to_reference_ground) |-> array_switch == 18'h20000 && busy)
    else $error("first trial is not the top bit");
  a_busy_span: assert property (
    $rose(busy) |-> ##20 busy ##1 !busy)
    else $error("busy length wrong");
  a_code_hold: assert property (
    busy |-> $stable(result_code))
    else $error("code moved during conversion");
  a_end_ground: assert property (
    $fell(busy) |-> pos_array_ground_switch && neg_array_ground_switch
    && !array_to_reference_ground)
    else $error("arrays not back in acquisition");
  // A fall forced by reset may be followed at once by a start
  a_rest_after: assert property (
    $fell(busy) && !$past(reset) |-> !busy[*3])
    else $error("restart too soon after busy fell");
  a_pd_refuse: assert property (
    !busy && power_down_in |=> !busy)
    else $error("conversion began in power-down");
  a_err_access: assert property (pslverr |-> psel && penable && pready)
    else $error("error outside access phase");
endmodule : sar_seq_checker

bind sar_conversion_sequencer sar_seq_checker u_sar_seq_checker (
  .ref_clk, .reset, .conversion_start_n, .power_down_in, .busy,
  .pos_array_ground_switch, .neg_array_ground_switch,
  .array_to_reference_ground, .array_switch, .result_code,
  .psel, .penable, .pready, .pslverr
);

// >>> bench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic start_req,
  input wire logic [1:0] mode,
  input wire logic [17:0] sample,
  input wire logic [17:0] array_switch,
  output logic conversion_start_n,
  output logic fast_mode_in,
  output logic low_power_mode_in,
  output logic comparator_in
);
  // Start line low while a start is requested
  assign conversion_start_n = !start_req;
  // Mode pins from the chosen mode
  assign fast_mode_in = (mode == sar_seq_pkg::MODE_FAST);
  assign low_power_mode_in = (mode == sar_seq_pkg::MODE_LOW_POWER);
  // Keep trial bit while the array stays at or below the sample
  assign comparator_in = (array_switch <= sample);
endmodule : host_model

// >>> bench/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  bad_count++; $display("mismatch %0t %h %h", $time, g, e); end end
module testbench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic start_req = 1'b0;
  logic [1:0] mode = 2'b00;
  logic coding_select = 1'b0;
  logic full_width_mode_in = 1'b0;
  logic power_down_in = 1'b0;
  logic over_range_in = 1'b0;
  logic under_range_in = 1'b0;
  logic [17:0] sample = 18'h00000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int samples_checked = 0;
  wire conversion_start_n, fast_mode_in, low_power_mode_in, comparator_in;
  wire busy, pos_sw, neg_sw, to_gnd, power_save, result_stale;
  wire pready, pslverr;
  wire [17:0] array_switch, result_code;
  wire [31:0] prdata;

  // Clock, 50 ns period
  always #25 ref_clk = !ref_clk;

  host_model u_host_model (.start_req, .mode, .sample, .array_switch,
    .conversion_start_n, .fast_mode_in, .low_power_mode_in, .comparator_in);

  sar_conversion_sequencer #(.GAP_CYCLES(50), .FIFO_DEPTH(16))
    u_sar_conversion_sequencer (.ref_clk, .reset, .conversion_start_n,
    .fast_mode_in, .low_power_mode_in, .coding_select, .full_width_mode_in,
    .power_down_in, .comparator_in, .over_range_in, .under_range_in, .busy,
    .pos_array_ground_switch(pos_sw), .neg_array_ground_switch(neg_sw),
    .array_to_reference_ground(to_gnd), .array_switch, .power_save,
    .result_code, .result_stale, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a);
    step(1);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    step(1);
    penable <= 1'b1;
    do step(1); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Write transfer; data set before the setup cycle
  task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
    pwdata <= d;
    apb(1'b1, a);
  endtask : apb_wr

  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 100 && busy !== lvl; i++) step(1);
    `CHK(busy, lvl)
  endtask : wait_busy

  task automatic pulse;
    start_req <= 1'b1;
    step(1);
    start_req <= 1'b0;
  endtask : pulse

  task automatic convert(input logic [17:0] s);
    sample <= s;
    pulse();
    wait_busy(1'b1);
    wait_busy(1'b0);
    step(20);
  endtask : convert

  // Empty the result buffer
  task automatic drain;
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, 12'h008);
      if (rd[31] !== 1'b1) break;
    end
  endtask : drain

  task automatic t_stale;
    mode <= 2'b01;
    convert(18'h00100);
    `CHK(result_stale, 1'b1)
    convert(18'h00200);
    `CHK(result_stale, 1'b0)
    step(60);
    convert(18'h00300);
    `CHK(result_stale, 1'b1)
  endtask : t_stale

  task automatic t_codes;
    logic [17:0] s [4] = '{18'h00000, 18'h20000, 18'h3FFFF, 18'h1ABCD};
    for (int c = 0; c < 3; c++) for (int i = 0; i < 4; i++) begin
      coding_select <= (c != 0);
      full_width_mode_in <= (c == 2);
      convert(s[i]);
      `CHK(result_code, (c == 1) ? s[i] ^ 18'h20000 : s[i])
    end
    full_width_mode_in <= 1'b0;
  endtask : t_codes

  task automatic t_sat;
    for (int c = 0; c < 2; c++) begin
      coding_select <= c[0];
      over_range_in <= 1'b1;
      convert(18'h00000);
      `CHK(result_code, c ? 18'h1FFFF : 18'h3FFFF)
      over_range_in <= 1'b0;
      under_range_in <= 1'b1;
      convert(18'h3FFFF);
      `CHK(result_code, c ? 18'h20000 : 18'h00000)
      under_range_in <= 1'b0;
    end
    coding_select <= 1'b0;
  endtask : t_sat

  // Second edge while busy is lost
  task automatic t_busy;
    pulse();
    step(5);
    pulse();
    wait_busy(1'b0);
    repeat (10) begin
      step(1);
      `CHK(busy, 1'b0)
    end
  endtask : t_busy

  task automatic t_pd;
    pulse();
    power_down_in <= 1'b1;
    wait_busy(1'b1);
    wait_busy(1'b0);
    step(20);
    pulse();
    step(30);
    `CHK(busy, 1'b0)
    `CHK(power_save, 1'b1)
    power_down_in <= 1'b0;
    step(20);
  endtask : t_pd

  task automatic t_modes;
    for (int m = 0; m < 3; m++) begin
      mode <= m[1:0];
      apb(1'b0, 12'h004);
      `CHK(rd[4:3], m[1:0])
    end
    step(2);
    `CHK(power_save, 1'b1)
    pulse();
    wait_busy(1'b1);
    start_req <= 1'b1;
    wait_busy(1'b0);
    wait_busy(1'b1);
    start_req <= 1'b0;
    wait_busy(1'b0);
    mode <= 2'b00;
    step(40);
  endtask : t_modes

  task automatic t_reset;
    pulse();
    step(5);
    reset <= 1'b1;
    step(1);
    reset <= 1'b0;
    step(1);
    `CHK({busy, to_gnd, pos_sw, neg_sw}, 4'b0011)
    convert(18'h00ABC);
    `CHK(result_code, 18'h00ABC)
  endtask : t_reset

  // Fill buffer to refusal, then drain in order
  task automatic t_fifo;
    apb(1'b0, 12'h000);
    `CHK(rd[1:0], 2'b01)
    apb(1'b0, 12'h00C);
    `CHK(err, 1'b1)
    drain();
    for (int i = 0; i < 16; i++) convert(18'(i * 3 + 1));
    pulse();
    step(30);
    apb(1'b0, 12'h004);
    `CHK({rd[12:8], rd[6], rd[2:1]}, 8'h86)
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 12'h008);
      `CHK({rd[31], rd[17:0]}, {1'b1, 18'(i * 3 + 1)})
    end
    apb(1'b0, 12'h004);
    `CHK(rd[1], 1'b1)
  endtask : t_fifo

  // Control writes: overflow clear, disable, stale drop
  task automatic t_ctrl;
    apb_wr(12'h004, 32'h00000040);
    apb(1'b0, 12'h004);
    `CHK(rd[6], 1'b0)
    apb_wr(12'h000, 32'h00000000);
    pulse();
    step(30);
    `CHK(busy, 1'b0)
    apb_wr(12'h000, 32'h00000003);
    mode <= 2'b01;
    step(60);
    convert(18'h00123);
    `CHK(result_stale, 1'b1)
    apb(1'b0, 12'h004);
    `CHK({rd[7], rd[1]}, 2'b01)
    mode <= 2'b00;
  endtask : t_ctrl

  // Watchdog
  initial begin
    step(20000);
    bad_count++;
    test_done();
  end

  initial begin
    step(12);
    reset <= 1'b0;
    t_stale();
    drain();
    t_codes();
    drain();
    t_sat();
    drain();
    t_busy();
    t_pd();
    t_modes();
    drain();
    t_reset();
    t_fifo();
    t_ctrl();
    test_done();
  end
endmodule : testbench
